//--- rtl/llcc_pkg.sv
// Purpose: shared constants for the locked loop clock configuration block
// Assumes: 16-bit registers, one per 32-bit Wishbone word
// Notes:   byte address of a register is four times its index
package llcc_pkg;
    localparam logic [7:0]  IDX_ENABLE   = 8'h74;
    localparam logic [7:0]  IDX_DIVIDER  = 8'h75;
    localparam logic [7:0]  IDX_FRACTION = 8'h76;
    localparam logic [7:0]  IDX_INTEGER  = 8'h77;
    localparam logic [7:0]  IDX_REFSEL   = 8'h78;
    localparam logic [7:0]  IDX_STATUS   = 8'h7f;
    localparam int          NUM_CFG      = 5;

    // field positions
    localparam int FRACN_BIT  = 2;
    localparam int OSC_BIT    = 1;
    localparam int ENA_BIT    = 0;
    localparam int OUTDIV_LSB = 8;
    localparam int OUTDIV_MSB = 13;
    localparam int RATE_LSB   = 4;
    localparam int RATE_MSB   = 6;
    localparam int RATIO_LSB  = 0;
    localparam int RATIO_MSB  = 2;
    localparam int FRAC_LSB   = 0;
    localparam int FRAC_MSB   = 15;
    localparam int INT_LSB    = 5;
    localparam int INT_MSB    = 14;
    localparam int GAIN_LSB   = 0;
    localparam int GAIN_MSB   = 3;
    localparam int PREDIV_LSB = 3;
    localparam int PREDIV_MSB = 4;
    localparam int SRC_LSB    = 0;
    localparam int SRC_MSB    = 1;

    // reset values and writable-bit masks, indexed by slot
    localparam logic [15:0] CFG_RESET [NUM_CFG] =
        '{16'h0000, 16'h0007, 16'h0000, 16'h2ee0, 16'h0000};
    localparam logic [15:0] CFG_MASK [NUM_CFG] =
        '{16'h0007, 16'h3f77, 16'hffff, 16'h7fef, 16'h001b};

    localparam logic [5:0] OUTDIV_MIN = 6'h03;
    localparam logic [3:0] GAIN_MAX   = 4'h8;
    localparam logic [1:0] SRC_MASTER = 2'h0;
    localparam logic [1:0] SRC_BIT    = 2'h1;
    localparam logic [1:0] SRC_FRAME  = 2'h2;

    typedef enum logic [1:0] {
        LS_OFF = 2'b00,
        LS_OSC = 2'b01,
        LS_RUN = 2'b11
    } llcc_state_t;
endpackage

//--- rtl/llcc_div_if.sv
// Purpose: carries one tick divider's controls and its output pulse
// Assumes: all signals in the clk domain
// Notes:   max is the division ratio minus one
interface llcc_div_if;
    logic       en;
    logic       tick;
    logic [5:0] max;
    logic       pulse;
    modport div (input en, input tick, input max, output pulse);
    modport ctl (output en, output tick, output max, input pulse);
endinterface

//--- rtl/llcc_tick_div.sv
// Purpose: divides a stream of one-cycle ticks by max plus one
// Assumes: ticks are one clk cycle wide
// Notes:   pulse lags the final tick of each period by one cycle
module llcc_tick_div (
    input  wire logic clk,
    input  wire logic rst_b,
    llcc_div_if.div   d
);
    logic [5:0] cnt_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r   <= 6'h00;
            d.pulse <= 1'b0;
        end else if (!d.en) begin
            cnt_r   <= 6'h00;
            d.pulse <= 1'b0;
        end else if (d.tick) begin
            // >= so a ratio lowered mid-period cannot strand the count
            if (cnt_r >= d.max) begin
                cnt_r   <= 6'h00;
                d.pulse <= 1'b1;
            end else begin
                cnt_r   <= cnt_r + 6'h01;
                d.pulse <= 1'b0;
            end
        end else begin
            d.pulse <= 1'b0;
        end
    end
endmodule // llcc_tick_div

//--- rtl/llcc_ref_select.sv
// Purpose: picks the reference clock input and marks its rising edges
// Assumes: clock inputs are already synchronous to clk
// Notes:   reserved source code gives no edges at all
module llcc_ref_select
    import llcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       mclk,
    input  wire logic       bclk,
    input  wire logic       lrclk,
    input  wire logic [1:0] src,
    output logic            ref_edge
);
    logic sel_lvl;
    logic prev_r;

    always_comb begin
        case (src)
            SRC_MASTER: sel_lvl = mclk;
            SRC_BIT:    sel_lvl = bclk;
            SRC_FRAME:  sel_lvl = lrclk;
            default:    sel_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_r   <= 1'b0;
            ref_edge <= 1'b0;
        end else begin
            prev_r   <= sel_lvl;
            ref_edge <= sel_lvl & ~prev_r;
        end
    end
endmodule // llcc_ref_select

//--- rtl/llcc_top.sv
// Purpose: register file and clock dividers of the frequency locked loop
// Assumes: classic Wishbone slave, 32-bit data, 16-bit registers
// Notes:   oscillator itself is outside; osc_tick marks its cycles
//
// What this block does
// - bit 2 picks integer or fractional mode
// - oscillator enable only counts in free-run
// - bit 0 turns loop on, off by default
// - output divider divides by code plus one; codes below 3 give no output
// - control rate divides oscillator by code plus one
// - ratio divider: 1, 2, 4, 8, else 16
// - sixteen-bit fractional multiplier, top bit half
// - ten-bit integer multiplier, default 0x177
// - error gain is two to the code
// - reference pre-divider by 1, 2, 4, 8
// - source: master, bit, frame clock; 11 reserved
//
// Register access over Wishbone was chosen for this implementation.
module llcc_top
    import llcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [31:0] wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_wr,
    output logic [31:0]      wb_dat_rd,
    output logic             wb_ack,
    input  wire logic        mclk,
    input  wire logic        bclk,
    input  wire logic        lrclk,
    input  wire logic        osc_tick,
    input  wire logic        free_run,
    output logic             osc_run,
    output logic             loop_run,
    output logic             frac_mode,
    output logic [15:0]      frac_mult,
    output logic [9:0]       int_mult,
    output logic [3:0]       gain_shift,
    output logic [4:0]       osc_ratio,
    output logic             ref_tick,
    output logic             ratio_tick,
    output logic             ctrl_tick,
    output logic             loop_out_tick
);
    import llcc_pkg::*;

    logic [15:0] cfg_r [NUM_CFG];
    llcc_state_t state_r;
    llcc_state_t state_nxt;
    logic [4:0]  osc_ratio_r;
    logic [3:0]  gain_shift_r;

    logic [7:0]  idx;
    logic        in_page;
    logic        cfg_hit;
    logic [2:0]  slot;
    logic        req;
    logic        wr_go;
    logic [15:0] lane_mask;
    logic [15:0] rdata;
    logic        ref_edge;

    logic        loop_enable;
    logic        free_run_osc_enable;
    logic        fractional_mode_enable;
    logic [5:0]  output_divider;
    logic [2:0]  control_rate_divider;
    logic [2:0]  osc_ratio_divider;
    logic [15:0] fractional_multiplier;
    logic [9:0]  integer_multiplier;
    logic [3:0]  error_gain;
    logic [1:0]  reference_predivider;
    logic [1:0]  reference_source_select;
    logic        outdiv_ok;
    logic        src_ok;

    // bus decode
    assign idx       = wb_adr[9:2];
    assign in_page   = (wb_adr[31:10] == 22'h0) && (wb_adr[1:0] == 2'b00);
    assign cfg_hit   = in_page && (idx >= IDX_ENABLE) && (idx <= IDX_REFSEL);
    assign slot      = 3'(idx - IDX_ENABLE);
    assign req       = wb_cyc && wb_stb && !wb_ack;
    assign wr_go     = req && wb_we && cfg_hit;
    // sel[3:2] unused: registers are only sixteen bits wide
    assign lane_mask = {{8{wb_sel[1]}}, {8{wb_sel[0]}}};

    // field views of the register file
    assign fractional_mode_enable  = cfg_r[0][FRACN_BIT];
    assign free_run_osc_enable     = cfg_r[0][OSC_BIT];
    assign loop_enable             = cfg_r[0][ENA_BIT];
    assign output_divider          = cfg_r[1][OUTDIV_MSB:OUTDIV_LSB];
    assign control_rate_divider    = cfg_r[1][RATE_MSB:RATE_LSB];
    assign osc_ratio_divider       = cfg_r[1][RATIO_MSB:RATIO_LSB];
    assign fractional_multiplier   = cfg_r[2][FRAC_MSB:FRAC_LSB];
    assign integer_multiplier      = cfg_r[3][INT_MSB:INT_LSB];
    assign error_gain              = cfg_r[3][GAIN_MSB:GAIN_LSB];
    assign reference_predivider    = cfg_r[4][PREDIV_MSB:PREDIV_LSB];
    assign reference_source_select = cfg_r[4][SRC_MSB:SRC_LSB];

    // reserved codes are stored as written but never run the divider
    assign outdiv_ok = (output_divider >= OUTDIV_MIN);
    assign src_ok    = (reference_source_select != 2'b11);

    // register file: only documented bits are kept, the rest read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_r[i] <= CFG_RESET[i];
            end
        end else if (wr_go) begin
            cfg_r[slot] <= ((cfg_r[slot] & ~lane_mask)
                | (wb_dat_wr[15:0] & lane_mask)) & CFG_MASK[slot];
        end
    end

    always_comb begin
        rdata = 16'h0000;
        if (cfg_hit) begin
            rdata = cfg_r[slot];
        end else if (in_page && idx == IDX_STATUS) begin
            rdata = {12'h000, src_ok, outdiv_ok, state_r};
        end
    end

    // one wait state; unmapped addresses still ack and read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack    <= 1'b0;
            wb_dat_rd <= 32'h0000_0000;
        end else begin
            wb_ack    <= req;
            wb_dat_rd <= (req && !wb_we) ? {16'h0000, rdata} : 32'h0000_0000;
        end
    end

    // loop state: in locked modes the oscillator enable is ignored
    // free-run loop without its oscillator has no clock, so stays off
    always_comb begin
        state_nxt = LS_OFF;
        case ({free_run, free_run_osc_enable, loop_enable})
            3'b001, 3'b011: state_nxt = LS_RUN;
            3'b111:         state_nxt = LS_RUN;
            3'b110:         state_nxt = LS_OSC;
            default:        state_nxt = LS_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= LS_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign osc_run  = (state_r != LS_OFF);
    assign loop_run = (state_r == LS_RUN);

    // analogue-facing settings
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_ratio_r  <= 5'h10;
            gain_shift_r <= 4'h0;
        end else begin
            osc_ratio_r <= osc_ratio_divider[2] ? 5'h10
                : 5'(5'h01 << osc_ratio_divider[1:0]);
            // undefined codes above x256 saturate there
            gain_shift_r <= (error_gain > GAIN_MAX)
                ? GAIN_MAX : error_gain;
        end
    end

    assign frac_mode  = fractional_mode_enable;
    assign frac_mult  = fractional_multiplier;
    assign int_mult   = integer_multiplier;
    assign gain_shift = gain_shift_r;
    assign osc_ratio  = osc_ratio_r;

    // dividers
    // counters clear while the loop is off, so each enable starts clean
    llcc_div_if pre_div ();
    llcc_div_if rat_div ();
    llcc_div_if rate_div ();
    llcc_div_if out_div ();

    llcc_ref_select u_ref_select (
        .clk      (clk),
        .rst_b    (rst_b),
        .mclk     (mclk),
        .bclk     (bclk),
        .lrclk    (lrclk),
        .src      (reference_source_select),
        .ref_edge (ref_edge)
    );

    assign pre_div.en   = loop_run;
    assign pre_div.tick = ref_edge;
    assign pre_div.max  = 6'((6'h01 << reference_predivider) - 6'h01);

    assign rat_div.en   = loop_run;
    assign rat_div.tick = osc_tick;
    assign rat_div.max  = 6'(osc_ratio_r - 5'h01);

    assign rate_div.en   = loop_run;
    assign rate_div.tick = osc_tick;
    assign rate_div.max  = {3'b000, control_rate_divider};

    assign out_div.en   = loop_run && outdiv_ok;
    assign out_div.tick = osc_tick;
    assign out_div.max  = output_divider;

    llcc_tick_div u_pre_div (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (pre_div.div)
    );

    llcc_tick_div u_rat_div (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (rat_div.div)
    );

    llcc_tick_div u_rate_div (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (rate_div.div)
    );

    llcc_tick_div u_out_div (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (out_div.div)
    );

    assign ref_tick      = pre_div.pulse;
    assign ratio_tick    = rat_div.pulse;
    assign ctrl_tick     = rate_div.pulse;
    assign loop_out_tick = out_div.pulse;

    // checks
    logic [6:0] out_seen_r;
    logic       out_armed_r;

    // counts oscillator ticks between output pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_seen_r  <= 7'h00;
            out_armed_r <= 1'b0;
        end else begin
            if (loop_out_tick) begin
                out_seen_r <= {6'h00, osc_tick};
            end else if (osc_tick) begin
                out_seen_r <= out_seen_r + 7'h01;
            end
            if (!out_div.en || (wr_go && idx == IDX_DIVIDER)) begin
                out_armed_r <= 1'b0;
            end else if (loop_out_tick) begin
                out_armed_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence enable_wr_s;
        wr_go && idx == IDX_ENABLE && wb_sel[0];
    endsequence

    sequence locked_on_s;
        loop_enable && !free_run;
    endsequence

    sequence loop_idle_s;
        !loop_run;
    endsequence

    frac_mode_write_a: assert property (
        enable_wr_s |=> frac_mode == $past(wb_dat_wr[FRACN_BIT]))
        else $error("fractional mode does not follow write");

    osc_ignored_a: assert property (
        locked_on_s |=> loop_run)
        else $error("locked mode loop did not start");

    loop_off_a: assert property (
        enable_wr_s ##0 !wb_dat_wr[ENA_BIT] |=> ##1 !loop_run)
        else $error("loop still running after disable");

    out_period_a: assert property (
        loop_out_tick && out_armed_r
        |-> out_seen_r == {1'b0, output_divider} + 7'h01)
        else $error("output divider period wrong");

    rate_default_a: assert property (
        loop_run && control_rate_divider == 3'h0 && osc_tick
        |=> ctrl_tick)
        else $error("control tick missing at rate one");

    ratio_map_a: assert property (
        ##1 osc_ratio == ($past(osc_ratio_divider[2]) ? 5'h10
            : $past(osc_ratio_divider[1:0]) == 2'h3 ? 5'h08
            : $past(osc_ratio_divider[1:0]) == 2'h2 ? 5'h04
            : $past(osc_ratio_divider[1:0]) == 2'h1 ? 5'h02 : 5'h01))
        else $error("ratio factor mismatch");

    prediv_one_a: assert property (
        loop_run && reference_predivider == 2'h0 && ref_edge
        |=> ref_tick)
        else $error("reference tick missing at divide one");

    src_reserved_a: assert property (
        (reference_source_select == 2'b11)[*3] |-> !ref_tick)
        else $error("reference tick from reserved source");

    int_reserved_a: assert property (
        req && !wb_we && in_page && idx == IDX_INTEGER
        |=> wb_ack && wb_dat_rd[15] == 1'b0 && wb_dat_rd[4] == 1'b0)
        else $error("reserved integer register bits read set");

    bus_ack_a: assert property (
        wb_ack |-> wb_dat_rd[31:16] == 16'h0000 ##1 !wb_ack)
        else $error("ack held or upper data not zero");

    out_reserved_a: assert property (
        output_divider < OUTDIV_MIN |=> !loop_out_tick)
        else $error("output tick from reserved divider code");

    idle_quiet_a: assert property (
        loop_idle_s |=> !ref_tick && !ratio_tick && !ctrl_tick
            && !loop_out_tick)
        else $error("divider tick while loop is off");

    frac_hold_a: assert property (
        !(wr_go && idx == IDX_FRACTION) |=> $stable(frac_mult))
        else $error("fractional multiplier changed without write");

    int_hold_a: assert property (
        !(wr_go && idx == IDX_INTEGER) |=> $stable(int_mult))
        else $error("integer multiplier changed without write");

endmodule // llcc_top

//--- verif/test_llcc_top.sv
// Purpose: self-checking bench for the loop clock configuration block
// Assumes: classic Wishbone master, one access at a time, locked mode except for the free-run checks
// Notes:   tick counts are taken over whole divider periods, except ratio 16 over 24 ticks
module test_llcc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import llcc_pkg::*;

    // divider settings and tick counts expected over 24 oscillator ticks
    localparam logic [15:0] DIV_SET [5] =
        '{16'h0300, 16'h0511, 16'h0723, 16'h0274, 16'h0b52};
    localparam int E_OUT [5]  = '{6, 4, 3, 0, 2};
    localparam int E_CTRL [5] = '{24, 12, 8, 3, 4};
    localparam int E_RAT [5]  = '{24, 12, 3, 1, 6};
    // reference settings and edges expected over 24 master clock rises
    localparam logic [15:0] REF_SET [5] =
        '{16'h0000, 16'h0018, 16'h0009, 16'h000a, 16'h0003};
    localparam int E_REF [5]  = '{24, 3, 6, 3, 0};
    localparam logic [7:0] IDX [NUM_CFG] =
        '{IDX_ENABLE, IDX_DIVIDER, IDX_FRACTION, IDX_INTEGER, IDX_REFSEL};

    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic        wb_cyc    = 1'b0;
    logic        wb_stb    = 1'b0;
    logic        wb_we     = 1'b0;
    logic [31:0] wb_adr    = 32'h0;
    logic [3:0]  wb_sel    = 4'h0;
    logic [31:0] wb_dat_wr = 32'h0;
    logic [31:0] wb_dat_rd;
    logic        wb_ack;
    logic        mclk      = 1'b0;
    logic        bclk      = 1'b0;
    logic        lrclk     = 1'b0;
    logic        osc_tick  = 1'b0;
    logic        free_run  = 1'b0;
    logic        osc_run;
    logic        loop_run;
    logic        frac_mode;
    logic [15:0] frac_mult;
    logic [9:0]  int_mult;
    logic [3:0]  gain_shift;
    logic [4:0]  osc_ratio;
    logic        ref_tick;
    logic        ratio_tick;
    logic        ctrl_tick;
    logic        loop_out_tick;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n_ref;
    int          n_rat;
    int          n_ctrl;
    int          n_out;

    llcc_top uut (
        .clk(clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
        .mclk(mclk), .bclk(bclk), .lrclk(lrclk), .osc_tick(osc_tick),
        .free_run(free_run), .osc_run(osc_run), .loop_run(loop_run),
        .frac_mode(frac_mode), .frac_mult(frac_mult),
        .int_mult(int_mult), .gain_shift(gain_shift),
        .osc_ratio(osc_ratio), .ref_tick(ref_tick),
        .ratio_tick(ratio_tick), .ctrl_tick(ctrl_tick),
        .loop_out_tick(loop_out_tick)
    );

    always #2.5 clk = ~clk;

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(string what, int exp, int got);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask

    // request held until ack is sampled high; bounded wait
    task automatic wb_xfer(logic [7:0] idx, logic we, logic [3:0] sel,
                           logic [15:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc    <= 1'b1;
        wb_stb    <= 1'b1;
        wb_we     <= we;
        wb_adr    <= {22'h0, idx, 2'b00};
        wb_sel    <= sel;
        wb_dat_wr <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 16);
        q = wb_dat_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    task automatic wr(logic [7:0] idx, logic [15:0] d);
        logic [31:0] q;
        wb_xfer(idx, 1'b1, 4'h3, d, q);
    endtask

    task automatic rd(logic [7:0] idx, output logic [31:0] q);
        wb_xfer(idx, 1'b0, 4'hf, 16'h0, q);
    endtask

    // 24 oscillator ticks, reference clocks at three rates, then drain
    task automatic pump();
        n_ref = 0;
        n_rat = 0;
        n_ctrl = 0;
        n_out = 0;
        for (int k = 0; k < 56; k++) begin
            @(posedge clk);
            n_ref += (ref_tick === 1'b1);
            n_rat += (ratio_tick === 1'b1);
            n_ctrl += (ctrl_tick === 1'b1);
            n_out += (loop_out_tick === 1'b1);
            osc_tick <= (k < 48) && !k[0];
            mclk <= (k < 48) && k[0];
            bclk <= (k < 48) && k[1];
            lrclk <= (k < 48) && k[2];
        end
    endtask

    // dividers restart from zero only while the loop is off
    task automatic restart(logic [7:0] idx, logic [15:0] v);
        wr(IDX_ENABLE, 16'h0);
        wr(idx, v);
        wr(IDX_ENABLE, 16'h1);
        tick(2);
        pump();
    endtask

    initial begin
        logic [31:0] q;
        logic [3:0]  gv;
        logic [9:0]  nv;
        tick(20);
        rst_b <= 1'b1;
        chk_val("int_mult", 32'h177, {22'h0, int_mult});
        chk_val("osc_ratio", 32'h10, {27'h0, osc_ratio});
        chk_val("loop_run", 32'h0, {31'h0, loop_run});
        for (int i = 0; i < NUM_CFG; i++) begin
            rd(IDX[i], q);
            chk_val("reset value", {16'h0, CFG_RESET[i]}, q);
        end
        for (int i = 0; i < NUM_CFG; i++) begin
            wr(IDX[i], 16'hffff);
            rd(IDX[i], q);
            chk_val("ones back", {16'h0, CFG_MASK[i]}, q);
            wr(IDX[i], 16'h0);
            rd(IDX[i], q);
            chk_val("zero back", 32'h0, q);
        end
        wr(8'h79, 16'hffff);
        rd(8'h79, q);
        chk_val("unmapped", 32'h0, q);
        rd(IDX_STATUS, q);
        chk_val("status idle", 32'h8, q);
        wr(IDX_ENABLE, 16'h4);
        tick(2);
        chk_val("frac_mode", 32'h1, {31'h0, frac_mode});
        chk_val("loop_run off", 32'h0, {31'h0, loop_run});
        wr(IDX_FRACTION, 16'h8001);
        wb_xfer(IDX_FRACTION, 1'b1, 4'h1, 16'h1234, q);
        rd(IDX_FRACTION, q);
        chk_val("low lane", 32'h8034, q);
        chk_val("frac_mult", 32'h8034, {16'h0, frac_mult});
        for (int g = 0; g < 10; g++) begin
            gv = g[3:0];
            nv = 10'h155 + g[9:0];
            wr(IDX_INTEGER, {1'b0, nv, 1'b0, gv});
            tick(2);
            chk_val("int_mult", {22'h0, nv}, {22'h0, int_mult});
            chk_val("gain", (g > 8) ? 32'h8 : g, {28'h0, gain_shift});
        end
        for (int r = 0; r < 8; r++) begin
            wr(IDX_DIVIDER, {13'h0, r[2:0]});
            tick(2);
            chk_val("ratio", (r > 3) ? 32'h10 : (32'h1 << r),
                    {27'h0, osc_ratio});
        end
        wr(IDX_ENABLE, 16'h1);
        tick(2);
        chk_val("locked run", 32'h3, {30'h0, osc_run, loop_run});
        wr(IDX_ENABLE, 16'h0);
        tick(2);
        chk_val("disabled", 32'h0, {30'h0, osc_run, loop_run});
        free_run <= 1'b1;
        wr(IDX_ENABLE, 16'h1);
        tick(2);
        chk_val("no osc", 32'h0, {30'h0, osc_run, loop_run});
        wr(IDX_ENABLE, 16'h2);
        tick(2);
        chk_val("osc only", 32'h2, {30'h0, osc_run, loop_run});
        wr(IDX_ENABLE, 16'h3);
        tick(2);
        chk_val("free run", 32'h3, {30'h0, osc_run, loop_run});
        rd(IDX_STATUS, q);
        chk_val("status run", 32'hb, q);
        wr(IDX_ENABLE, 16'h0);
        free_run <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            restart(IDX_DIVIDER, DIV_SET[i]);
            chk_cnt("out ticks", E_OUT[i], n_out);
            chk_cnt("ctrl ticks", E_CTRL[i], n_ctrl);
            chk_cnt("ratio ticks", E_RAT[i], n_rat);
        end
        wr(IDX_DIVIDER, 16'h0300);
        for (int i = 0; i < 5; i++) begin
            restart(IDX_REFSEL, REF_SET[i]);
            chk_cnt("ref ticks", E_REF[i], n_ref);
        end
        // mid-run reset must bring loop_run, the integer register and the reference select register back to their defaults
        wr(IDX_INTEGER, 16'h1234);
        rst_b <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        chk_val("loop_run reset", 32'h0, {31'h0, loop_run});
        rd(IDX_INTEGER, q);
        chk_val("int reset", {16'h0, CFG_RESET[3]}, q);
        rd(IDX_REFSEL, q);
        chk_val("src reset", {16'h0, CFG_RESET[4]}, q);
        end_of_test();
    end
endmodule // test_llcc_top
